// ===== src/link_pkg.sv
package link_pkg;
  // Frame layout, byte positions inside one 48-byte frame
  localparam int FRAME_BYTES = 48;
  localparam logic [5:0] B_CODE = 6'h00;
  localparam logic [5:0] B_WDT = 6'h01;
  localparam logic [5:0] B_CTRL_LO = 6'h02;
  localparam logic [5:0] B_CTRL_HI = 6'h03;
  localparam logic [5:0] B_PAYLOAD = 6'h04;
  localparam logic [5:0] B_PAYLOAD_END = 6'h07;
  localparam logic [5:0] B_MAIN_LAST = 6'h1F;
  localparam logic [5:0] B_SUB_CODE = 6'h20;
  localparam logic [5:0] B_SUB_LAST = 6'h2F;

  // Control word fields
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int CTRL_TAG_LSB = 6;

  // Status word fields
  localparam int ST_DEV_ALARM = 0;
  localparam int ST_DEV_WARN = 1;
  localparam int ST_READY = 2;
  localparam int ST_CLR_DONE = 3;
  localparam int ST_TAG_LSB = 6;
  localparam int ST_CMD_FAULT_LSB = 8;
  localparam int ST_COMM_FAULT_LSB = 12;

  // Main command codes
  localparam logic [7:0] C_NO_OPERATION = 8'h00;
  localparam logic [7:0] C_IDENTITY_READ = 8'h03;
  localparam logic [7:0] C_CONFIGURE = 8'h04;
  localparam logic [7:0] C_FAULT_READ = 8'h05;
  localparam logic [7:0] C_FAULT_CLEAR = 8'h06;
  localparam logic [7:0] C_SYNC_REQUEST = 8'h0D;
  localparam logic [7:0] C_LINK_OPEN = 8'h0E;
  localparam logic [7:0] C_LINK_CLOSE_REQUEST = 8'h0F;
  localparam logic [7:0] C_BRAKE_APPLY = 8'h21;
  localparam logic [7:0] C_ENCODER_POWER_DOWN = 8'h24;
  localparam logic [7:0] C_DRIVE_MONITOR = 8'h30;
  localparam logic [7:0] C_POWER_STAGE_DISABLE = 8'h32;
  localparam logic [7:0] C_PATH_INTERPOLATION = 8'h34;
  localparam logic [7:0] C_CONSTANT_FEED = 8'h36;
  localparam logic [7:0] C_EXTERNAL_LATCH_MOVE = 8'h39;
  localparam logic [7:0] C_HOME_RETURN = 8'h3A;
  localparam logic [7:0] C_SPEED_REGULATION = 8'h3C;
  localparam logic [7:0] C_FORCE_REGULATION = 8'h3D;
  localparam logic [7:0] C_DRIVE_PARAM_READ = 8'h40;
  localparam logic [7:0] C_DRIVE_PARAM_WRITE = 8'h41;

  // Command fault codes and the communication fault code used
  localparam logic [3:0] F_NONE = 4'h0;
  localparam logic [3:0] F_UNSUPPORTED = 4'h8;
  localparam logic [3:0] F_PHASE = 4'hC;
  localparam logic [3:0] F_WATCHDOG = 4'h9;

  // Reset values
  localparam logic [7:0] WDT_RESET = 8'h00;
  localparam logic [1:0] TAG_RESET = 2'h0;

  // Communication phases, one-hot
  typedef enum logic [4:0] {
    PH_POWER = 5'b0_0001,
    PH_INIT = 5'b0_0010,
    PH_ASYNC = 5'b0_0100,
    PH_SYNC = 5'b0_1000,
    PH_CLOSE = 5'b1_0000
  } phase_t;

  // Host sequencer states, one-hot
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_SEND = 3'b010,
    HS_WAIT = 3'b100
  } host_state_t;
endpackage : link_pkg

// ===== src/frame_link_if.sv
`timescale 1ns/1ps
// Byte-serial frame link between master and drive
interface frame_link_if;
  // Master to drive
  logic m_valid;
  logic [7:0] m_data;
  logic m_last;
  // Drive to master
  logic s_valid;
  logic [7:0] s_data;
  logic s_last;

  modport dev_mp (
    input m_valid,
    input m_data,
    input m_last,
    output s_valid,
    output s_data,
    output s_last
  );

  modport host_mp (
    output m_valid,
    output m_data,
    output m_last,
    input s_valid,
    input s_data,
    input s_last
  );
endinterface : frame_link_if

// ===== src/code_classifier.sv
`timescale 1ns/1ps
// Sorts a command code into the classes the drive logic needs
module code_classifier (
  input wire logic [7:0] code,
  output logic supported,
  output logic sync_only,
  output logic tag_restart
);
  import link_pkg::*;

  // Known codes; motion streaming modes need the cyclic phase
  always_comb
  begin
    supported = 1'b1;
    sync_only = 1'b0;
    tag_restart = 1'b0;
    case (code)
      C_NO_OPERATION, C_IDENTITY_READ, C_CONFIGURE, C_FAULT_READ,
      C_FAULT_CLEAR, C_SYNC_REQUEST, C_LINK_OPEN,
      C_LINK_CLOSE_REQUEST: supported = 1'b1;
      8'h21, 8'h22, 8'h23, C_ENCODER_POWER_DOWN, C_DRIVE_MONITOR,
      8'h31, C_POWER_STAGE_DISABLE, 8'h35, C_CONSTANT_FEED,
      C_DRIVE_PARAM_READ, C_DRIVE_PARAM_WRITE:
        supported = 1'b1;
      C_PATH_INTERPOLATION, C_SPEED_REGULATION, C_FORCE_REGULATION:
        sync_only = 1'b1;
      C_EXTERNAL_LATCH_MOVE, C_HOME_RETURN:
        tag_restart = 1'b1;
      default: supported = 1'b0;
    endcase
  end
endmodule : code_classifier

// ===== src/drive_end.sv
`timescale 1ns/1ps
module drive_end (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // Link to master
  frame_link_if.dev_mp LINK,
  // Servo core status
  input wire logic INIT_DONE,
  input wire logic CORE_BUSY,
  input wire logic DEV_ALARM,
  input wire logic DEV_WARN,
  input wire logic [31:0] RSP_PAYLOAD,
  // Servo core commands
  output link_pkg::phase_t PHASE,
  output logic EXEC_STB,
  output logic [7:0] EXEC_CODE,
  output logic [1:0] EXEC_TAG,
  output logic [7:0] EXEC_ARG,
  output logic FAULT_CLEAR_STB,
  output logic [15:0] CTRL_WORD,
  output logic [3:0] COMM_FAULT
);
  import link_pkg::*;

  phase_t phase_ff;
  logic [5:0] rx_idx_ff;
  logic frame_ff;
  logic [7:0] rx_code_ff;
  logic [7:0] rx_wdt_ff;
  logic [7:0] rx_ctrl_ff;
  logic [7:0] rx_arg_ff;
  logic [7:0] rx_sub_ff;
  logic [7:0] cur_code_ff;
  logic [1:0] cur_tag_ff;
  logic [3:0] cmd_fault_ff;
  logic [3:0] comm_fault_ff;
  logic [7:0] wdt_prev_ff;
  logic wd_armed_ff;
  logic [7:0] slave_wdt_ff;
  logic clear_prev_ff;
  logic clr_done_ff;
  logic ready_ff;
  logic tx_start_ff;
  logic tx_active_ff;
  logic [5:0] tx_idx_ff;
  logic [31:0] payload_ff;
  logic s_valid_ff;
  logic [7:0] s_data_ff;
  logic s_last_ff;
  logic exec_stb_ff;
  logic [7:0] exec_code_ff;
  logic [1:0] exec_tag_ff;
  logic [7:0] exec_arg_ff;
  logic fault_clear_ff;
  logic [15:0] ctrl_word_ff;
  logic supported;
  logic sync_only;
  logic tag_restart;
  logic [1:0] rx_tag;
  logic [3:0] nxt_fault;
  logic accept;
  logic is_new;
  logic start;
  logic wd_bad;
  logic clear_edge;
  logic clear_req;
  logic [15:0] status;
  logic [7:0] nxt_s_data;

  code_classifier u_class (
    .code(rx_code_ff),
    .supported(supported),
    .sync_only(sync_only),
    .tag_restart(tag_restart)
  );

  assign rx_tag = rx_ctrl_ff[CTRL_TAG_LSB +: 2];

  // Capture code, watchdog and low control bytes, first payload byte and sub code by position; other payload bytes are not decoded here
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rx_idx_ff <= 6'h00;
      frame_ff <= 1'b0;
      rx_code_ff <= C_NO_OPERATION;
      rx_wdt_ff <= WDT_RESET;
      rx_ctrl_ff <= 8'h00;
      rx_arg_ff <= 8'h00;
      rx_sub_ff <= 8'h00;
    end
    else
    begin
      frame_ff <= LINK.m_valid && (LINK.m_last || rx_idx_ff == B_SUB_LAST);
      if (LINK.m_valid)
      begin
        rx_idx_ff <= (LINK.m_last || rx_idx_ff == B_SUB_LAST) ? 6'h00
                     : rx_idx_ff + 6'h01;
        case (rx_idx_ff)
          B_CODE: rx_code_ff <= LINK.m_data;
          B_WDT: rx_wdt_ff <= LINK.m_data;
          B_CTRL_LO: rx_ctrl_ff <= LINK.m_data;
          B_PAYLOAD: rx_arg_ff <= LINK.m_data;
          B_SUB_CODE: rx_sub_ff <= LINK.m_data;
          default: ; // High control byte and all other undecoded bytes dropped
        endcase
      end
    end
  end

  // Judge the received frame against phase, code and busy state
  always_comb
  begin
    nxt_fault = F_NONE;
    accept = 1'b0;
    if (!supported)
      nxt_fault = F_UNSUPPORTED;
    else if (phase_ff == PH_INIT && rx_code_ff != C_LINK_OPEN
             && rx_code_ff != C_NO_OPERATION)
      nxt_fault = F_PHASE;
    else if (sync_only && phase_ff != PH_SYNC)
      nxt_fault = F_PHASE;
    else if (rx_code_ff == C_SYNC_REQUEST && phase_ff != PH_ASYNC)
      nxt_fault = F_PHASE;
    else
      accept = 1'b1;
    // Same code again only counts as new for the two restartable moves
    is_new = rx_code_ff != cur_code_ff
             || (rx_tag != cur_tag_ff && tag_restart);
    // Busy core drops new commands, whatever their tag
    start = frame_ff && accept && is_new && ready_ff;
    wd_bad = frame_ff && phase_ff == PH_SYNC && wd_armed_ff
             && rx_wdt_ff != wdt_prev_ff + 8'h01;
    clear_edge = frame_ff && rx_ctrl_ff[CTRL_CLEAR_BIT] && !clear_prev_ff;
    clear_req = clear_edge || (start && rx_code_ff == C_FAULT_CLEAR
                               && rx_arg_ff[3:0] == 4'h0);
  end

  // Phase sequencing
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      phase_ff <= PH_POWER;
    else
      case (phase_ff)
        PH_POWER: phase_ff <= PH_INIT;
        PH_CLOSE: phase_ff <= PH_INIT;
        PH_INIT:
          if (start && rx_code_ff == C_LINK_OPEN && INIT_DONE)
            phase_ff <= PH_ASYNC;
        PH_ASYNC:
          if (start && rx_code_ff == C_LINK_CLOSE_REQUEST)
            phase_ff <= PH_CLOSE;
          else if (start && rx_code_ff == C_SYNC_REQUEST)
            phase_ff <= PH_SYNC;
        PH_SYNC:
          if (start && rx_code_ff == C_LINK_CLOSE_REQUEST)
            phase_ff <= PH_CLOSE;
          else if (wd_bad)
            phase_ff <= PH_ASYNC; // Watchdog alarm drops cyclic mode
        default: phase_ff <= PH_INIT;
      endcase
  end

  // Current command, tag and fault codes; closing the link wipes them
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cur_code_ff <= C_NO_OPERATION;
      cur_tag_ff <= TAG_RESET;
      cmd_fault_ff <= F_NONE;
      comm_fault_ff <= F_NONE;
    end
    else if (phase_ff == PH_CLOSE)
    begin
      cur_code_ff <= C_NO_OPERATION;
      cur_tag_ff <= TAG_RESET;
      cmd_fault_ff <= F_NONE;
      comm_fault_ff <= F_NONE;
    end
    else
    begin
      if (start)
      begin
        cur_code_ff <= rx_code_ff;
        cur_tag_ff <= rx_tag;
      end
      if (frame_ff)
        cmd_fault_ff <= nxt_fault; // Normal frame clears it
      // Set wins over a clear arriving in the same frame
      if (wd_bad)
        comm_fault_ff <= F_WATCHDOG;
      else if (clear_req)
        comm_fault_ff <= F_NONE;
    end
  end

  // Watchdog tracking and fault clear bookkeeping
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wdt_prev_ff <= WDT_RESET;
      wd_armed_ff <= 1'b0;
      clear_prev_ff <= 1'b0;
      clr_done_ff <= 1'b0;
      ready_ff <= 1'b0;
    end
    else
    begin
      ready_ff <= !CORE_BUSY;
      if (phase_ff != PH_SYNC)
        wd_armed_ff <= 1'b0;
      else if (frame_ff)
        wd_armed_ff <= 1'b1;
      if (frame_ff)
      begin
        wdt_prev_ff <= rx_wdt_ff;
        // Acted on even if the same frame raised a command fault
        clear_prev_ff <= rx_ctrl_ff[CTRL_CLEAR_BIT];
        if (clear_edge)
          clr_done_ff <= 1'b1;
        else if (!rx_ctrl_ff[CTRL_CLEAR_BIT])
          clr_done_ff <= 1'b0;
      end
    end
  end

  // Requests towards the servo core
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      exec_stb_ff <= 1'b0;
      exec_code_ff <= C_NO_OPERATION;
      exec_tag_ff <= TAG_RESET;
      exec_arg_ff <= 8'h00;
      fault_clear_ff <= 1'b0;
      ctrl_word_ff <= 16'h0000;
    end
    else
    begin
      exec_stb_ff <= start;
      fault_clear_ff <= clear_req;
      if (start)
      begin
        exec_code_ff <= rx_code_ff;
        exec_tag_ff <= rx_tag;
        exec_arg_ff <= rx_arg_ff;
      end
      if (frame_ff)
        ctrl_word_ff <= {8'h00, rx_ctrl_ff & 8'hC8};
    end
  end

  // Status word; unused positions stay zero
  always_comb
  begin
    status = 16'h0000;
    status[ST_DEV_ALARM] = DEV_ALARM;
    status[ST_DEV_WARN] = DEV_WARN;
    status[ST_READY] = ready_ff;
    status[ST_CLR_DONE] = clr_done_ff;
    status[ST_TAG_LSB +: 2] = cur_tag_ff;
    status[ST_CMD_FAULT_LSB +: 4] = cmd_fault_ff;
    status[ST_COMM_FAULT_LSB +: 4] = comm_fault_ff;
    if (tx_idx_ff == B_CODE)
      nxt_s_data = rx_code_ff;
    else if (tx_idx_ff == B_WDT)
      nxt_s_data = slave_wdt_ff;
    else if (tx_idx_ff == B_CTRL_LO)
      nxt_s_data = status[7:0];
    else if (tx_idx_ff == B_CTRL_HI)
      nxt_s_data = status[15:8];
    else if (tx_idx_ff >= B_PAYLOAD && tx_idx_ff <= B_PAYLOAD_END)
      nxt_s_data = payload_ff[8 * (tx_idx_ff[1:0]) +: 8];
    else if (tx_idx_ff == B_SUB_CODE)
      nxt_s_data = rx_sub_ff;
    else
      nxt_s_data = 8'h00; // Rest of main and subcommand areas
  end

  // Response sender; one frame follows each received frame
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      tx_start_ff <= 1'b0;
      tx_active_ff <= 1'b0;
      tx_idx_ff <= 6'h00;
      payload_ff <= 32'h0000_0000;
      slave_wdt_ff <= WDT_RESET;
      s_valid_ff <= 1'b0;
      s_data_ff <= 8'h00;
      s_last_ff <= 1'b0;
    end
    else
    begin
      tx_start_ff <= frame_ff;
      if (tx_start_ff)
      begin
        tx_active_ff <= 1'b1;
        tx_idx_ff <= 6'h00;
        payload_ff <= RSP_PAYLOAD;
      end
      else if (tx_active_ff)
      begin
        tx_idx_ff <= tx_idx_ff + 6'h01;
        if (tx_idx_ff == B_SUB_LAST)
        begin
          tx_active_ff <= 1'b0;
          // Refreshed from reset, well before any connect
          slave_wdt_ff <= slave_wdt_ff + 8'h01;
        end
      end
      s_valid_ff <= tx_active_ff;
      s_data_ff <= tx_active_ff ? nxt_s_data : 8'h00;
      s_last_ff <= tx_active_ff && tx_idx_ff == B_SUB_LAST;
    end
  end

  assign LINK.s_valid = s_valid_ff;
  assign LINK.s_data = s_data_ff;
  assign LINK.s_last = s_last_ff;
  assign PHASE = phase_ff;
  assign EXEC_STB = exec_stb_ff;
  assign EXEC_CODE = exec_code_ff;
  assign EXEC_TAG = exec_tag_ff;
  assign EXEC_ARG = exec_arg_ff;
  assign FAULT_CLEAR_STB = fault_clear_ff;
  assign CTRL_WORD = ctrl_word_ff;
  assign COMM_FAULT = comm_fault_ff;
endmodule : drive_end

// ===== src/master_end.sv
`timescale 1ns/1ps
// Master side: sends one 48-byte command frame and collects the answer
module master_end (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // Link to drive
  frame_link_if.host_mp LINK,
  // User request
  input wire logic REQ,
  input wire logic [7:0] REQ_CODE,
  input wire logic [1:0] REQ_TAG,
  input wire logic REQ_CLEAR,
  input wire logic [7:0] REQ_ARG,
  input wire logic [7:0] REQ_SUB,
  // User answer
  output logic BUSY,
  output logic DONE,
  output logic [7:0] RSP_CODE,
  output logic [7:0] RSP_WDT,
  output logic [15:0] RSP_STATUS
);
  import link_pkg::*;

  host_state_t state_ff;
  logic [5:0] idx_ff;
  logic [7:0] code_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] arg_ff;
  logic [7:0] sub_ff;
  logic [7:0] wdt_ff;
  logic m_valid_ff;
  logic [7:0] m_data_ff;
  logic m_last_ff;
  logic done_ff;
  logic [7:0] rsp_code_ff;
  logic [7:0] rsp_wdt_ff;
  logic [15:0] rsp_status_ff;
  logic [7:0] nxt_byte;

  // Outgoing byte for the current position; unused bytes are zero
  always_comb
  begin
    case (idx_ff)
      B_CODE: nxt_byte = code_ff;
      B_WDT: nxt_byte = wdt_ff;
      B_CTRL_LO: nxt_byte = ctrl_ff;
      B_PAYLOAD: nxt_byte = arg_ff;
      B_SUB_CODE: nxt_byte = sub_ff;
      default: nxt_byte = 8'h00;
    endcase
  end

  // Request latch and frame sequencing; requests while busy are dropped
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_ff <= HS_IDLE;
      idx_ff <= 6'h00;
      code_ff <= C_NO_OPERATION;
      ctrl_ff <= 8'h00;
      arg_ff <= 8'h00;
      sub_ff <= 8'h00;
      wdt_ff <= WDT_RESET;
      m_valid_ff <= 1'b0;
      m_data_ff <= 8'h00;
      m_last_ff <= 1'b0;
    end
    else
    begin
      m_valid_ff <= state_ff == HS_SEND;
      m_data_ff <= state_ff == HS_SEND ? nxt_byte : 8'h00;
      m_last_ff <= state_ff == HS_SEND && idx_ff == B_SUB_LAST;
      case (state_ff)
        HS_IDLE:
          if (REQ)
          begin
            state_ff <= HS_SEND;
            idx_ff <= 6'h00;
            code_ff <= REQ_CODE;
            // Caller changes the tag to mark a repeated C_EXTERNAL_LATCH_MOVE or C_HOME_RETURN as new
            ctrl_ff <= {REQ_TAG, 2'b00, REQ_CLEAR, 3'b000};
            arg_ff <= REQ_ARG;
            sub_ff <= REQ_SUB;
            wdt_ff <= wdt_ff + 8'h01;
          end
        HS_SEND:
          if (idx_ff == B_SUB_LAST)
          begin
            state_ff <= HS_WAIT;
            idx_ff <= 6'h00;
          end
          else
            idx_ff <= idx_ff + 6'h01;
        HS_WAIT:
          if (LINK.s_valid)
          begin
            idx_ff <= LINK.s_last ? 6'h00 : idx_ff + 6'h01;
            if (LINK.s_last)
              state_ff <= HS_IDLE;
          end
        default: state_ff <= HS_IDLE;
      endcase
    end
  end

  // Response header capture
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      done_ff <= 1'b0;
      rsp_code_ff <= 8'h00;
      rsp_wdt_ff <= 8'h00;
      rsp_status_ff <= 16'h0000;
    end
    else
    begin
      done_ff <= state_ff == HS_WAIT && LINK.s_valid && LINK.s_last;
      if (state_ff == HS_WAIT && LINK.s_valid)
        case (idx_ff)
          B_CODE: rsp_code_ff <= LINK.s_data;
          B_WDT: rsp_wdt_ff <= LINK.s_data;
          B_CTRL_LO: rsp_status_ff[7:0] <= LINK.s_data;
          B_CTRL_HI: rsp_status_ff[15:8] <= LINK.s_data;
          default: ;
        endcase
    end
  end

  assign LINK.m_valid = m_valid_ff;
  assign LINK.m_data = m_data_ff;
  assign LINK.m_last = m_last_ff;
  assign BUSY = state_ff != HS_IDLE;
  assign DONE = done_ff;
  assign RSP_CODE = rsp_code_ff;
  assign RSP_WDT = rsp_wdt_ff;
  assign RSP_STATUS = rsp_status_ff;
endmodule : master_end

// ===== bench/bench_codes_pkg.sv
package bench_codes_pkg;
  // Every code the drive must decode, common set first
  localparam logic [7:0] KNOWN [24] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h0D, 8'h0E, 8'h0F, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30, 8'h31, 8'h32,
    8'h34, 8'h35, 8'h36, 8'h39, 8'h3A, 8'h3C, 8'h3D, 8'h40, 8'h41};

  // Kept apart from the design's classifier so a shared slip cannot hide
  function automatic logic is_known(input logic [7:0] c);
    is_known = 1'b0;
    foreach (KNOWN[i])
      if (KNOWN[i] == c)
        is_known = 1'b1;
  endfunction : is_known
endpackage : bench_codes_pkg

// ===== bench/link_properties.sv
`timescale 1ns/1ps
module link_properties
  import bench_codes_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // Master to drive
  input wire logic m_valid,
  input wire logic [7:0] m_data,
  input wire logic m_last,
  // Drive to master
  input wire logic s_valid,
  input wire logic [7:0] s_data,
  input wire logic s_last
);
  logic [5:0] idx_ff;
  logic [7:0] code_ff;
  logic [7:0] sub_ff;
  logic [7:0] mwdt_ff;
  logic [7:0] wdt_ff;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  // Byte position inside the command frame
  always_ff @(posedge REF_CLK or negedge ARST_N)
    if (!ARST_N)
      idx_ff <= 6'h00;
    else if (m_valid)
      idx_ff <= m_last ? 6'h00 : idx_ff + 6'h01;

  // Header bytes of the frame in flight, held for the response
  always_ff @(posedge REF_CLK or negedge ARST_N)
    if (!ARST_N)
    begin
      code_ff <= 8'h00;
      sub_ff <= 8'h00;
      mwdt_ff <= 8'h00;
    end
    else if (m_valid)
    begin
      if (idx_ff == 6'h00)
        code_ff <= m_data;
      if (idx_ff == 6'h01)
        mwdt_ff <= m_data;
      if (idx_ff == 6'h20)
        sub_ff <= m_data;
    end

  // Responses sent so far; the drive's watchdog byte must track it
  always_ff @(posedge REF_CLK or negedge ARST_N)
    if (!ARST_N)
      wdt_ff <= 8'h00;
    else if (s_valid && s_last)
      wdt_ff <= wdt_ff + 8'h01;

  last_byte_a: assert property (m_valid && m_last |-> idx_ff == 6'h2F)
    else $error("frame closed away from byte 47");
  resp_start_a: assert property (m_valid && m_last |-> ##4 s_valid)
    else $error("response did not start four cycles after frame end");
  resp_len_a: assert property ($rose(s_valid) |-> ##47 s_valid && s_last)
    else $error("response not 48 bytes long");
  resp_end_a: assert property (s_valid && s_last |=> !s_valid)
    else $error("response ran past its last byte");
  code_echo_a: assert property ($rose(s_valid) |-> s_data == code_ff)
    else $error("byte 0 is not the received code");
  sub_echo_a: assert property ($rose(s_valid) |-> ##32 s_data == sub_ff)
    else $error("byte 32 is not the received sub code");
  slave_wdt_a: assert property ($rose(s_valid) |=> s_data == wdt_ff)
    else $error("slave watchdog byte does not count responses");
  rsv_zero_a: assert property ($rose(s_valid) |-> ##2 s_data[5:4] == 2'b00)
    else $error("reserved status bits not zero");
  unsup_fault_a: assert property (
    $rose(s_valid) && !is_known(code_ff) |-> ##3 s_data[3:0] == 4'h8)
    else $error("unsupported code without fault 8");
  master_wdt_a: assert property (
    m_valid && idx_ff == 6'h01 |-> m_data == mwdt_ff + 8'h01)
    else $error("master watchdog byte did not step by one");
endmodule : link_properties

// ===== bench/servo_link_command_header_tb.sv
`timescale 1ns/1ps
module servo_link_command_header_tb;
  import link_pkg::*;
  import bench_codes_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic init_done = 1'b0;
  logic core_busy = 1'b0;
  logic dev_alarm = 1'b0;
  logic dev_warn = 1'b0;
  logic [31:0] rsp_payload = 32'h0000_0000;
  logic req = 1'b0;
  logic [7:0] req_code = 8'h00;
  logic [1:0] req_tag = 2'h0;
  logic req_clear = 1'b0;
  logic [7:0] req_arg = 8'h00;
  logic [7:0] req_sub = 8'h00;
  logic busy, done, exec_stb, clr_stb, clr_stb_b;
  logic [7:0] rsp_code, rsp_wdt, rc, cur;
  logic [15:0] rsp_status;
  logic [3:0] comm_b;
  logic [1:0] cur_tag;
  logic prev_clr, clr_done;
  phase_t phase, phase_b, ph;
  int failures, compares, execs, clears, clears_b, rr, k;
  int seed = 99829;
  frame_link_if link();
  frame_link_if link_b();

  master_end i_master_end (.REF_CLK(ref_clk), .ARST_N(arst_n), .LINK(link),
    .REQ(req), .REQ_CODE(req_code), .REQ_TAG(req_tag), .REQ_CLEAR(req_clear),
    .REQ_ARG(req_arg), .REQ_SUB(req_sub), .BUSY(busy), .DONE(done),
    .RSP_CODE(rsp_code), .RSP_WDT(rsp_wdt), .RSP_STATUS(rsp_status));
  drive_end i_drive_end (.REF_CLK(ref_clk), .ARST_N(arst_n), .LINK(link),
    .INIT_DONE(init_done), .CORE_BUSY(core_busy), .DEV_ALARM(dev_alarm),
    .DEV_WARN(dev_warn), .RSP_PAYLOAD(rsp_payload), .PHASE(phase),
    .EXEC_STB(exec_stb), .EXEC_CODE(), .EXEC_TAG(), .EXEC_ARG(),
    .FAULT_CLEAR_STB(clr_stb), .CTRL_WORD(), .COMM_FAULT());
  // Second drive faces the bench, which can break the master's rules
  drive_end i_drive_end_b (.REF_CLK(ref_clk), .ARST_N(arst_n), .LINK(link_b),
    .INIT_DONE(init_done), .CORE_BUSY(core_busy), .DEV_ALARM(dev_alarm),
    .DEV_WARN(dev_warn), .RSP_PAYLOAD(rsp_payload), .PHASE(phase_b),
    .EXEC_STB(), .EXEC_CODE(), .EXEC_TAG(), .EXEC_ARG(),
    .FAULT_CLEAR_STB(clr_stb_b), .CTRL_WORD(), .COMM_FAULT(comm_b));
  link_properties i_link_properties (.REF_CLK(ref_clk), .ARST_N(arst_n),
    .m_valid(link.m_valid), .m_data(link.m_data), .m_last(link.m_last),
    .s_valid(link.s_valid), .s_data(link.s_data), .s_last(link.s_last));

  // Clock
  always #2 ref_clk = ~ref_clk;

  // Strobe counters; pulses last one cycle so every edge is looked at
  always @(posedge ref_clk)
  begin
    execs += (exec_stb === 1'b1);
    clears += (clr_stb === 1'b1);
    clears_b += (clr_stb_b === 1'b1);
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // Expected command fault for a code in a given phase
  function automatic logic [3:0] fault_of(input logic [7:0] c, phase_t p);
    if (!is_known(c))
      return F_UNSUPPORTED;
    if (p == PH_INIT && c != C_NO_OPERATION && c != C_LINK_OPEN)
      return F_PHASE;
    if (c inside {8'h34, 8'h3C, 8'h3D} && p != PH_SYNC)
      return F_PHASE;
    if (c == C_SYNC_REQUEST && p != PH_ASYNC)
      return F_PHASE;
    return F_NONE;
  endfunction : fault_of

  // One command through the master, response checked against the model
  task automatic send(input logic [7:0] c, input logic [1:0] t,
                      input logic clr, input logic tag_ok);
    logic [3:0] f;
    logic go;
    logic cd;
    int n0;
    int k0;
    f = fault_of(c, ph);
    go = f == F_NONE && !core_busy && (c != cur || (t != cur_tag
      && c inside {C_EXTERNAL_LATCH_MOVE, C_HOME_RETURN}));
    cd = clr && (clr_done || !prev_clr);
    n0 = execs;
    k0 = clears;
    @(negedge ref_clk);
    req_code = c;
    req_tag = t;
    req_clear = clr;
    req_arg = 8'($random(seed));
    req_sub = 8'($random(seed));
    {dev_alarm, dev_warn} = 2'($random(seed));
    rsp_payload = $random(seed);
    req = 1'b1;
    @(negedge ref_clk);
    req = 1'b0;
    for (int i = 0; i < 300 && done !== 1'b1; i++)
      @(negedge ref_clk);
    check("echo", rsp_code, c);
    check("wdt", rsp_wdt, 16'(k));
    k++;
    check("fault", rsp_status[11:8], f);
    check("ready", rsp_status[2:0], {!core_busy, dev_warn, dev_alarm});
    check("clear done", rsp_status[3], cd);
    check("reserved", {rsp_status[15:12], rsp_status[5:4]}, 16'h0000);
    if (tag_ok)
      check("tag", rsp_status[7:6], go ? t : cur_tag);
    check("starts", 16'(execs - n0), go);
    check("clears", 16'(clears - k0), (clr && !prev_clr) ||
      (go && c == C_FAULT_CLEAR && req_arg[3:0] == 4'h0));
    if (go)
    begin
      cur = c;
      cur_tag = t;
    end
    if (f == F_NONE && c == C_LINK_OPEN && init_done && ph == PH_INIT)
      ph = PH_ASYNC;
    if (f == F_NONE && c == C_SYNC_REQUEST)
      ph = PH_SYNC;
    if (f == F_NONE && c == C_LINK_CLOSE_REQUEST && ph != PH_INIT)
    begin
      ph = PH_INIT;
      cur = C_NO_OPERATION;
      cur_tag = 2'h0;
    end
    check("phase", phase, ph);
    prev_clr = clr;
    clr_done = cd;
  endtask : send

  // Raw frame to the second drive; idle data lines are inverted
  task automatic raw(input logic [7:0] c, w, ctl);
    for (int i = 0; i < 48; i++)
    begin
      @(negedge ref_clk);
      link_b.m_valid = 1'b1;
      link_b.m_data = i == 0 ? c : i == 1 ? w : i == 2 ? ctl : 8'h00;
      link_b.m_last = i == 47;
    end
    @(negedge ref_clk);
    link_b.m_valid = 1'b0;
    link_b.m_last = 1'b0;
    link_b.m_data = ~link_b.m_data;
    for (int i = 0; i < 300 && link_b.s_last !== 1'b1; i++)
      @(negedge ref_clk);
    repeat (3) @(negedge ref_clk);
  endtask : raw

  // Main sequence
  initial
  begin
    {link_b.m_valid, link_b.m_last, link_b.m_data} = 10'h000;
    {ph, cur, cur_tag, prev_clr, clr_done} = {PH_INIT, 12'h000};
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("phase", phase, PH_INIT);
    send(C_LINK_OPEN, 2'h0, 1'b0, 1'b1);
    send(8'h07, 2'h1, 1'b1, 1'b1);
    send(8'h31, 2'h2, 1'b0, 1'b1);
    send(C_NO_OPERATION, 2'h0, 1'b0, 1'b1);
    init_done = 1'b1;
    send(C_LINK_OPEN, 2'h1, 1'b0, 1'b1);
    send(C_PATH_INTERPOLATION, 2'h1, 1'b0, 1'b1);
    send(C_SYNC_REQUEST, 2'h2, 1'b0, 1'b1);
    foreach (KNOWN[i])
      if (!(KNOWN[i] inside {C_SYNC_REQUEST, C_LINK_CLOSE_REQUEST}))
        send(KNOWN[i], 2'($random(seed)), 1'b0, 1'b1);
    send(C_EXTERNAL_LATCH_MOVE, 2'h1, 1'b0, 1'b1);
    send(C_EXTERNAL_LATCH_MOVE, 2'h2, 1'b0, 1'b1);
    send(8'h31, 2'h1, 1'b0, 1'b1);
    send(8'h31, 2'h3, 1'b0, 1'b1);
    core_busy = 1'b1;
    send(C_POWER_STAGE_DISABLE, 2'h0, 1'b0, 1'b1);
    core_busy = 1'b0;
    repeat (24)
    begin
      rr = $random(seed);
      rc = rr[7] ? KNOWN[rr[4:0] % 24] : rr[7:0];
      rc = rc == C_LINK_CLOSE_REQUEST ? C_NO_OPERATION : rc;
      send(rc, rr[9:8], rr[10], 1'b1);
    end
    send(C_LINK_CLOSE_REQUEST, 2'h0, 1'b0, 1'b0);
    send(C_LINK_OPEN, 2'h3, 1'b0, 1'b1);
    raw(C_LINK_OPEN, 8'h01, 8'h00);
    raw(C_SYNC_REQUEST, 8'h07, 8'h00);
    check("b phase", phase_b, PH_SYNC);
    check("b comm", comm_b, F_NONE);
    raw(C_NO_OPERATION, 8'h08, 8'h00);
    raw(C_NO_OPERATION, 8'h03, 8'h00);
    check("b comm", comm_b, F_WATCHDOG);
    check("b phase", phase_b, PH_ASYNC);
    k = clears_b;
    raw(C_NO_OPERATION, 8'h04, 8'h08);
    check("b comm", comm_b, F_NONE);
    check("b clears", 16'(clears_b - k), 16'h0001);
    end_sim();
  end

  // Cuts a hung run short; the sequence needs under 10000 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_sim();
  end
endmodule : servo_link_command_header_tb
